// ===== hdl/nact_pkg.sv
package nact_pkg;
    // Field widths of the timing settings and requests, select count and counter width
    localparam int SETUP_W  = 4;
    localparam int STROBE_W = 6;
    localparam int HOLD_W   = 3;
    localparam int TA_W     = 2;
    localparam int NSEL     = 4;
    localparam int SEL_W    = 2;
    localparam int ADDR_W   = 23;
    localparam int DATA_W   = 16;
    localparam int CNT_W    = 6;

    // Reset values of the timing fields (all maximum, safe for slow parts)
    localparam logic [SETUP_W-1:0]  SETUP_RST  = 4'hf;
    localparam logic [STROBE_W-1:0] STROBE_RST = 6'h3f;
    localparam logic [HOLD_W-1:0]   HOLD_RST   = 3'h7;
    localparam logic [TA_W-1:0]     TA_RST     = 2'h3;

    // Timing of one direction of cycle
    typedef struct packed {
        logic [SETUP_W-1:0]  setup;
        logic [STROBE_W-1:0] strobe;
        logic [HOLD_W-1:0]   hold;
    } nact_phase_t;

    // Per-select async configuration
    typedef struct packed {
        nact_phase_t         wr;
        nact_phase_t         rd;
        logic [TA_W-1:0]     turnaroundLen;
    } nact_cfg_t;

    // One single asynchronous cycle request
    typedef struct packed {
        logic              write;
        logic [SEL_W-1:0]  sel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } nact_req_t;

    localparam nact_cfg_t CFG_RST = '{
        wr: '{setup: SETUP_RST, strobe: STROBE_RST, hold: HOLD_RST},
        rd: '{setup: SETUP_RST, strobe: STROBE_RST, hold: HOLD_RST},
        turnaroundLen: TA_RST};

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TURN,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } nact_state_t;
endpackage

// ===== hdl/nact_engine.sv
// Notes on behaviour
// - Separate read and write timing per select
// - One request makes one single cycle
// - Command and address phases are writes
// - Data phase writes to program, reads
// - Field value N gives N+1 cycles
// - Turnaround gap between read then write
// - Data bus undriven during turnaround gap
`timescale 1ns/10ps
module nact_engine (
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            rst,
    // Per-select configuration
    input  wire nact_pkg::nact_cfg_t             cfgIn [nact_pkg::NSEL],
    // Request side
    input  wire logic                            reqValid,
    input  wire nact_pkg::nact_req_t             reqIn,
    output logic                                 reqReady,
    output logic                                 rdValid,
    output logic [nact_pkg::DATA_W-1:0]          rdData,
    // Flash pins
    output logic [nact_pkg::NSEL-1:0]            chipSelN,
    output logic                                 writeEnableN,
    output logic                                 outputEnableStrobeN,
    output logic [nact_pkg::ADDR_W-1:0]          memAddr,
    output logic [nact_pkg::DATA_W-1:0]          memDataOut,
    output logic                                 memDataOeN,
    input  wire logic [nact_pkg::DATA_W-1:0]     memDataIn
);
    nact_pkg::nact_state_t            state_q;
    nact_pkg::nact_req_t              cur_q;
    nact_pkg::nact_phase_t            ph_q;
    logic [nact_pkg::CNT_W-1:0]       cnt_q;
    logic                             lastRead_q;
    logic                             accept;
    logic [nact_pkg::CNT_W:0]         strobeLen_q;

    // A request is taken only while idle
    assign accept = reqValid && reqReady;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= nact_pkg::ST_IDLE;
            cur_q      <= '0;
            ph_q       <= '0;
            cnt_q      <= '0;
            lastRead_q <= 1'b0;
        end else begin
            case (state_q)
                nact_pkg::ST_IDLE: begin
                    if (accept) begin
                        cur_q <= reqIn;
                        ph_q <= reqIn.write ? cfgIn[reqIn.sel].wr : cfgIn[reqIn.sel].rd;
                        if (reqIn.write && lastRead_q) begin
                            state_q <= nact_pkg::ST_TURN;
                            cnt_q   <= nact_pkg::CNT_W'(cfgIn[reqIn.sel].turnaroundLen);
                        end else begin
                            state_q <= nact_pkg::ST_SETUP;
                            cnt_q   <= nact_pkg::CNT_W'(reqIn.write
                                ? cfgIn[reqIn.sel].wr.setup : cfgIn[reqIn.sel].rd.setup);
                        end
                    end
                end
                nact_pkg::ST_TURN: begin
                    if (cnt_q == '0) begin
                        state_q <= nact_pkg::ST_SETUP;
                        cnt_q   <= nact_pkg::CNT_W'(ph_q.setup);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                nact_pkg::ST_SETUP: begin
                    if (cnt_q == '0) begin
                        state_q <= nact_pkg::ST_STROBE;
                        cnt_q   <= ph_q.strobe;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                nact_pkg::ST_STROBE: begin
                    if (cnt_q == '0) begin
                        state_q <= nact_pkg::ST_HOLD;
                        cnt_q   <= nact_pkg::CNT_W'(ph_q.hold);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                nact_pkg::ST_HOLD: begin
                    if (cnt_q == '0) begin
                        state_q    <= nact_pkg::ST_IDLE;
                        lastRead_q <= !cur_q.write;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: state_q <= nact_pkg::ST_IDLE;
            endcase
        end
    end

    // Ready is registered: high only in idle, dropped on acceptance
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqReady <= 1'b0;
        end else if (accept) begin
            reqReady <= 1'b0;
        end else begin
            reqReady <= (state_q == nact_pkg::ST_IDLE) ||
                        (state_q == nact_pkg::ST_HOLD && cnt_q == '0);
        end
    end

    // pins trail the state by one stage; counters run down to zero, so each phase is field+1 long
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chipSelN            <= '1;
            writeEnableN        <= 1'b1;
            outputEnableStrobeN <= 1'b1;
            memAddr             <= '0;
            memDataOut          <= '0;
            memDataOeN          <= 1'b1;
        end else begin
            // commands and addresses go out as writes
            memAddr    <= cur_q.addr;
            memDataOut <= cur_q.wdata;
            case (state_q)
                nact_pkg::ST_SETUP: begin
                    chipSelN            <= '1;
                    chipSelN[cur_q.sel] <= 1'b0;
                    writeEnableN        <= 1'b1;
                    outputEnableStrobeN <= 1'b1;
                    memDataOeN          <= !cur_q.write;
                end
                nact_pkg::ST_STROBE: begin
                    chipSelN            <= '1;
                    chipSelN[cur_q.sel] <= 1'b0;
                    writeEnableN        <= !cur_q.write;
                    outputEnableStrobeN <= cur_q.write;
                    memDataOeN          <= !cur_q.write;
                end
                nact_pkg::ST_HOLD: begin
                    // Data stays driven through hold to meet the flash's data hold
                    chipSelN            <= '1;
                    chipSelN[cur_q.sel] <= 1'b0;
                    writeEnableN        <= 1'b1;
                    outputEnableStrobeN <= 1'b1;
                    memDataOeN          <= !cur_q.write;
                end
                default: begin
                    // bus released in turnaround and idle
                    chipSelN            <= '1;
                    writeEnableN        <= 1'b1;
                    outputEnableStrobeN <= 1'b1;
                    memDataOeN          <= 1'b1;
                end
            endcase
        end
    end

    // Read data taken at the end of the last strobe cycle, while the pin is still low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdValid <= 1'b0;
            rdData  <= '0;
        end else begin
            rdValid <= 1'b0;
            if (state_q == nact_pkg::ST_HOLD && !outputEnableStrobeN) begin
                rdValid <= 1'b1;
                rdData  <= memDataIn;
            end
        end
    end

    // Length of the strobe now running, so the check needs no long repetition
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobeLen_q <= '0;
        end else if (!writeEnableN || !outputEnableStrobeN) begin
            strobeLen_q <= strobeLen_q + 1'b1;
        end else begin
            strobeLen_q <= '0;
        end
    end

    a_strobe_len: assert property (@(posedge clk) disable iff (rst)
        ($rose(writeEnableN) || $rose(outputEnableStrobeN)) |->
            (strobeLen_q == {1'b0, ph_q.strobe} + 1'b1))
        else $error("strobe length wrong");
    a_turn_quiet: assert property (@(posedge clk) disable iff (rst)
        $past(state_q == nact_pkg::ST_TURN) |-> memDataOeN)
        else $error("data driven in turnaround");
    a_cs_strobe: assert property (@(posedge clk) disable iff (rst)
        (!writeEnableN || !outputEnableStrobeN) |-> !(&chipSelN))
        else $error("strobe without select");
    a_rd_nodrive: assert property (@(posedge clk) disable iff (rst)
        !outputEnableStrobeN |-> memDataOeN)
        else $error("driving during read strobe");
    a_one_strobe: assert property (@(posedge clk) disable iff (rst)
        $rose(writeEnableN) |-> writeEnableN [*2])
        else $error("second strobe in cycle");
    a_turn_after: assert property (@(posedge clk) disable iff (rst)
        (state_q == nact_pkg::ST_TURN) |-> lastRead_q && cur_q.write)
        else $error("turnaround without read");
    a_wr_drive: assert property (@(posedge clk) disable iff (rst)
        !writeEnableN |-> !memDataOeN)
        else $error("write strobe without data");
    a_one_dir: assert property (@(posedge clk) disable iff (rst)
        !(!writeEnableN && !outputEnableStrobeN))
        else $error("both strobes low");

    c_write: cover property (@(posedge clk) disable iff (rst) $rose(writeEnableN));
    c_short: cover property (@(posedge clk) disable iff (rst)
        $rose(outputEnableStrobeN) && strobeLen_q == 7'h1);
    c_read: cover property (@(posedge clk) disable iff (rst) rdValid);
    c_turn: cover property (@(posedge clk) disable iff (rst) state_q == nact_pkg::ST_TURN);
endmodule

// ===== tb/nact_flash_model.sv
`timescale 1ns/10ps
// Flash data outputs: drives only while selected and the read strobe is low
module nact_flash_model (
    // Clock
    input  wire logic                        clk,
    // Flash pins
    input  wire logic [nact_pkg::NSEL-1:0]   chipSelN,
    input  wire logic                        outputEnableStrobeN,
    input  wire logic [nact_pkg::ADDR_W-1:0] memAddr,
    output logic [nact_pkg::DATA_W-1:0]      memDataIn
);
    logic                        drive;
    logic [nact_pkg::DATA_W-1:0] held;
    assign drive = (chipSelN != '1) && !outputEnableStrobeN;
    // Released bus keeps the last word for one cycle, then toggles so a stale word does not stay valid
    always_ff @(posedge clk) begin
        held <= drive ? memAddr[15:0] ^ 16'h5a5a : ~held;
    end
    assign memDataIn = drive ? memAddr[15:0] ^ 16'h5a5a : held;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    typedef struct {bit wr; int sel, addr, wd, su, st, ho, ta;} nact_exp_t;
    logic clk = 0, rst = 1, reqValid = 0, reqReady, rdValid;
    logic writeEnableN, outputEnableStrobeN, memDataOeN;
    nact_pkg::nact_cfg_t cfg [nact_pkg::NSEL];
    nact_pkg::nact_req_t reqIn = '0;
    logic [15:0] rdData, memDataOut, memDataIn;
    logic [3:0] chipSelN;
    logic [22:0] memAddr;
    nact_exp_t expQ[$], cur;
    int rdQ[$], num_errors = 0, comparisons = 0, su, st, ho, gap = 0;
    bit inCyc = 0, lastRd = 0;
    nact_engine i_nact_engine (.clk(clk), .rst(rst), .cfgIn(cfg), .reqValid(reqValid),
        .reqIn(reqIn), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
        .chipSelN(chipSelN), .writeEnableN(writeEnableN), .memAddr(memAddr),
        .outputEnableStrobeN(outputEnableStrobeN), .memDataOut(memDataOut),
        .memDataOeN(memDataOeN), .memDataIn(memDataIn));
    nact_flash_model i_nact_flash_model (.clk(clk), .chipSelN(chipSelN), .memAddr(memAddr),
        .outputEnableStrobeN(outputEnableStrobeN), .memDataIn(memDataIn));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkData(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t read word %h expected %h", $time, g, e);
        end
    endtask
    task automatic summarize;
        if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One request, held until accepted; expectation taken from its select's setting
    task automatic doReq(input bit wr, input int sel, input int addr, input int wd);
        nact_pkg::nact_phase_t p;
        int n;
        p = wr ? cfg[sel].wr : cfg[sel].rd;
        reqValid <= 1;
        reqIn <= '{write: wr, sel: sel[1:0], addr: addr[22:0], wdata: wd[15:0]};
        for (n = 0; n < 300 && reqReady !== 1; n++) @(posedge clk);
        @(posedge clk);
        if (n == 300) begin
            num_errors++;
            summarize();
        end
        expQ.push_back('{wr, sel, addr[22:0], wd[15:0], p.setup + 1, p.strobe + 1,
            p.hold + 1, cfg[sel].turnaroundLen + 1});
        if (!wr) rdQ.push_back(addr[15:0] ^ 16'h5a5a);
        reqValid <= 0;
        @(posedge clk);
    endtask
    task automatic drain;
        for (int n = 0; n < 900 && (expQ.size() > 0 || inCyc); n++) @(posedge clk);
        chk(expQ.size() + inCyc, 0); // one cycle each
        if (expQ.size() > 0 || inCyc) summarize();
    endtask
    // Pin monitor: phase lengths, select, strobes, data and gap per cycle
    always @(posedge clk) begin
        if (!rst && chipSelN !== 4'hf) begin
            if (!inCyc) begin
                inCyc = 1; su = 0; st = 0; ho = 0;
                cur = expQ.pop_front();
                if (cur.wr && lastRd) chk(gap >= cur.ta, 1); // turnaround
                chk({28'h0, ~chipSelN}, 32'h1 << cur.sel); // per select
                chk(memAddr, cur.addr); // address
            end
            if (!writeEnableN || !outputEnableStrobeN) begin
                st++;
                chk({writeEnableN, outputEnableStrobeN, memDataOeN}, cur.wr ? 3'h2 : 3'h5);
                if (cur.wr) chk(memDataOut, cur.wd); // write data
            end else if (st == 0) su++;
            else ho++;
        end else if (!rst) begin
            if (inCyc) begin
                chk(su, cur.su); // setup length
                chk(st, cur.st); // strobe length
                chk(ho, cur.ho); // hold length
                inCyc = 0; lastRd = !cur.wr; gap = 0;
            end
            gap++;
            if (lastRd) chk(memDataOeN, 1); // bus released
        end
        if (rdValid === 1) chkData(rdData, rdQ.pop_front()); // read data
    end
    initial begin
        void'($urandom(32'hd3fc8fb2));
        // slowest settings cover latch setup and hold
        for (int i = 0; i < 4; i++) cfg[i] = nact_pkg::CFG_RST;
        repeat (5) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        // NAND program then read: command, address, data as single cycles
        doReq(1, 2, 0, 16'h0080); // command
        doReq(1, 2, 1, 16'h0012); // address
        doReq(1, 2, 2, 16'hbeef); // program data
        doReq(0, 2, 5, 0); // read data
        doReq(1, 2, 0, 16'h0070); // write after read
        drain();
        // Zero settings, then random settings with separate read and write timing
        for (int b = 0; b < 6; b++) begin
            @(posedge clk);
            for (int i = 0; i < 4; i++) cfg[i] <= (b == 0) ? '0 : $urandom;
            @(posedge clk);
            for (int k = 0; k < 12; k++) doReq($urandom % 2, $urandom % 4, $urandom, $urandom);
            drain();
        end
        chk(rdQ.size(), 0); // one result per read
        summarize();
    end
endmodule
